// File: core/ara_pkg.sv
// Purpose: constants for the range and aperture register pair
// Assumes: 4-bit register address, 16-bit register data
// Notes:   every offset, field position and reset value lives here
package ara_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MAG_W = 15;
  localparam int unsigned COARSE_W = 12;
  localparam int unsigned FINE_W = 6;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_RANGE = 4'hB;
  localparam logic [ADDR_W-1:0] ADDR_APERTURE = 4'hC;

  // power-on values
  localparam logic [DATA_W-1:0] RANGE_RESET = 16'h4000;
  localparam logic [DATA_W-1:0] APERTURE_RESET = 16'h0004;

  // range register fields
  localparam int unsigned MAG_LSB = 0;
  localparam int unsigned MAG_MSB = 14;

  // aperture register fields
  localparam int unsigned COARSE_LSB = 4;
  localparam int unsigned COARSE_MSB = 15;
  localparam int unsigned SELECT_BIT = 3;
  localparam int unsigned DCS_BIT = 2;

  // code limits
  localparam logic [MAG_W-1:0] MAG_MIN = 15'h4000;
  localparam logic [MAG_W-1:0] MAG_MAX = 15'h7FFF;
  localparam logic [COARSE_W-1:0] COARSE_MAX = 12'h97F;

endpackage

// File: core/ara_delay_if.sv
// Purpose: carries aperture settings from the register file to the delay control
// Assumes: both ends on the same clock
// Notes:   applied codes are registered by the control end
`timescale 1ns/100ps
interface ara_delay_if;
  logic [11:0] coarse_delay_code;
  logic [5:0]  fine_delay_code;
  logic        delay_adjust_select;
  logic [11:0] coarse_applied;
  logic [5:0]  fine_applied;
  logic        coarse_saturated;

  modport regs (
    output coarse_delay_code,
    output fine_delay_code,
    output delay_adjust_select,
    input  coarse_applied,
    input  fine_applied,
    input  coarse_saturated
  );

  modport ctrl (
    input  coarse_delay_code,
    input  fine_delay_code,
    input  delay_adjust_select,
    output coarse_applied,
    output fine_applied,
    output coarse_saturated
  );
endinterface

// File: core/ara_delay_ctrl.sv
// Purpose: turns stored aperture settings into the delay actually applied
// Assumes: same clock as the register file
// Notes:   one cycle of latency from register to applied code
`timescale 1ns/100ps
module ara_delay_ctrl (
  // clock and reset
  input wire logic  clock,
  input wire logic  reset_n,
  // settings in, applied codes out
  ara_delay_if.ctrl dly
);

  logic [11:0] coarse_q;
  logic [11:0] coarse_d;
  logic [5:0]  fine_q;
  logic [5:0]  fine_d;
  logic        sat_q;
  logic        sat_d;

  always_comb begin
    sat_d = dly.coarse_delay_code > ara_pkg::COARSE_MAX;
    coarse_d = sat_d ? ara_pkg::COARSE_MAX : dly.coarse_delay_code;
    fine_d = dly.fine_delay_code;
    // no programmed delay while adjust is deselected
    if (!dly.delay_adjust_select) begin
      coarse_d = 12'h000;
      fine_d = 6'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      coarse_q <= 12'h000;
      fine_q <= 6'h00;
      sat_q <= 1'b0;
    end else begin
      coarse_q <= coarse_d;
      fine_q <= fine_d;
      sat_q <= sat_d;
    end
  end

  assign dly.coarse_applied = coarse_q;
  assign dly.fine_applied = fine_q;
  assign dly.coarse_saturated = sat_q;

endmodule

// File: core/ara_regs.sv
// Purpose: full-scale range and aperture delay configuration registers
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   fine delay register lives elsewhere and arrives as an input
//          stored aperture fields feed the analog side straight from their flops; range goes out as a floored copy one cycle later
`timescale 1ns/100ps
module ara_regs (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // mode and neighbouring settings
  input  wire logic        extended_control_mode,
  input  wire logic [5:0]  fine_delay_code,
  // analog controls
  output logic      [14:0] range_magnitude,
  output logic      [11:0] coarse_delay_code,
  output logic             delay_adjust_select,
  output logic             duty_cycle_stabilizer_en,
  output logic      [11:0] coarse_delay_applied,
  output logic      [5:0]  fine_delay_applied,
  output logic             coarse_delay_saturated
);

  // stored fields; reserved bits get no flops
  logic [14:0] range_field_q;
  logic [14:0] range_field_d;

  logic [11:0] coarse_q;
  logic [11:0] coarse_d;

  logic        select_q;
  logic        select_d;

  logic        dcs_q;
  logic        dcs_d;

  // read port and applied range code
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [14:0] mag_q;
  logic [14:0] mag_d;

  // decoded strobes
  logic        range_wr;
  logic        aperture_wr;

  logic        range_rd;
  logic        aperture_rd;

  // carrier to the delay control
  ara_delay_if dly ();

  // one compare serves the write and the read decode
  function automatic logic addr_hit(
    input logic [3:0] a,
    input logic [3:0] off
  );
    logic hit;
    hit = (a == off);
    return hit;
  endfunction

  // field helpers, used on write data and on reset values alike
  function automatic logic [14:0] mag_field(
    input logic [15:0] w
  );
    logic [14:0] m;
    m = w[ara_pkg::MAG_MSB:ara_pkg::MAG_LSB];
    return m;
  endfunction

  function automatic logic [11:0] coarse_field(
    input logic [15:0] w
  );
    logic [11:0] c;
    c = w[ara_pkg::COARSE_MSB:ara_pkg::COARSE_LSB];
    return c;
  endfunction

  function automatic logic select_field(
    input logic [15:0] w
  );
    logic s;
    s = w[ara_pkg::SELECT_BIT];
    return s;
  endfunction

  function automatic logic dcs_field(
    input logic [15:0] w
  );
    logic e;
    e = w[ara_pkg::DCS_BIT];
    return e;
  endfunction

  // bit 15 has no flop, so it reads back as zero
  function automatic logic [15:0] range_word(
    input logic [14:0] m
  );
    logic [15:0] v;
    v = 16'h0000;
    v[ara_pkg::MAG_MSB:ara_pkg::MAG_LSB] = m;
    return v;
  endfunction

  // bits 1:0 have no flops, so they read back as zero
  function automatic logic [15:0] aperture_word(
    input logic [11:0] c,
    input logic        s,
    input logic        e
  );
    logic [15:0] v;
    v = 16'h0000;
    v[ara_pkg::COARSE_MSB:ara_pkg::COARSE_LSB] = c;
    v[ara_pkg::SELECT_BIT] = s;
    v[ara_pkg::DCS_BIT] = e;
    return v;
  endfunction

  // below the floor only in extended mode; otherwise the range stays legal
  function automatic logic [14:0] mag_floor(
    input logic [14:0] m,
    input logic        ext
  );
    logic [14:0] v;
    v = m;
    if (!ext && m < ara_pkg::MAG_MIN) begin
      v = ara_pkg::MAG_MIN;
    end
    return v;
  endfunction

  // write decode
  always_comb begin
    range_wr = 1'b0;
    aperture_wr = 1'b0;
    if (reg_wr) begin
      range_wr = addr_hit(reg_addr, ara_pkg::ADDR_RANGE);
      aperture_wr = addr_hit(reg_addr, ara_pkg::ADDR_APERTURE);
    end
  end

  // read decode; the master never raises both strobes at once
  always_comb begin
    range_rd = 1'b0;
    aperture_rd = 1'b0;
    if (reg_rd) begin
      range_rd = addr_hit(reg_addr, ara_pkg::ADDR_RANGE);
      aperture_rd = addr_hit(reg_addr, ara_pkg::ADDR_APERTURE);
    end
  end

  // range magnitude field
  always_comb begin
    range_field_d = range_field_q;
    if (range_wr) begin
      range_field_d = mag_field(reg_wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // lowest legal code after reset
      range_field_q <= mag_field(ara_pkg::RANGE_RESET);
    end else begin
      range_field_q <= range_field_d;
    end
  end

  // coarse delay field
  // codes above the clamp are kept as written; the control end clamps
  always_comb begin
    coarse_d = coarse_q;
    if (aperture_wr) begin
      coarse_d = coarse_field(reg_wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      coarse_q <= coarse_field(ara_pkg::APERTURE_RESET);
    end else begin
      coarse_q <= coarse_d;
    end
  end

  // delay adjust select
  // clearing it drops both coarse and fine delay at the control end
  always_comb begin
    select_d = select_q;
    if (aperture_wr) begin
      select_d = select_field(reg_wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // delay adjust off after reset
      select_q <= select_field(ara_pkg::APERTURE_RESET);
    end else begin
      select_q <= select_d;
    end
  end

  // duty-cycle stabilizer enable
  always_comb begin
    dcs_d = dcs_q;
    if (aperture_wr) begin
      dcs_d = dcs_field(reg_wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // stabilizer on after reset
      dcs_q <= dcs_field(ara_pkg::APERTURE_RESET);
    end else begin
      dcs_q <= dcs_d;
    end
  end

  // read data stand one cycle, then fall back to zero; unmapped reads give zero
  always_comb begin
    rdata_d = 16'h0000;
    if (range_rd) begin
      rdata_d = range_word(range_field_q);
    end
    if (aperture_rd) begin
      rdata_d = aperture_word(coarse_q, select_q, dcs_q);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // applied range code trails the stored field by one cycle
  // the stored field stays as written; only the applied code is floored
  always_comb begin
    mag_d = mag_floor(range_field_q, extended_control_mode);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mag_q <= mag_field(ara_pkg::RANGE_RESET);
    end else begin
      mag_q <= mag_d;
    end
  end

  // delay control clamps and gates the stored fields itself
  // fine code is already stored next door, so it passes straight through
  assign dly.coarse_delay_code = coarse_q;
  assign dly.fine_delay_code = fine_delay_code;
  assign dly.delay_adjust_select = select_q;

  ara_delay_ctrl u_delay (
    .clock   (clock),
    .reset_n (reset_n),
    .dly     (dly.ctrl)
  );

  // read port
  assign reg_rdata = rdata_q;

  // analog controls, straight from the flops
  assign range_magnitude = mag_q;
  assign coarse_delay_code = coarse_q;
  assign delay_adjust_select = select_q;
  assign duty_cycle_stabilizer_en = dcs_q;

  // applied delay, one cycle behind the stored fields
  assign coarse_delay_applied = dly.coarse_applied;
  assign fine_delay_applied = dly.fine_applied;
  assign coarse_delay_saturated = dly.coarse_saturated;

endmodule

// File: testbench/ara_regs_sva.sv
// Purpose: port checks for the range and aperture registers
// Assumes: one clock domain
// Notes:   range check only for codes at or above the floor
`timescale 1ns/100ps
module ara_regs_sva (
  input wire logic        clock, reset_n, reg_wr, reg_rd, delay_adjust_select,
  input wire logic        duty_cycle_stabilizer_en, coarse_delay_saturated,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  input wire logic [14:0] range_magnitude,
  input wire logic [11:0] coarse_delay_code, coarse_delay_applied,
  input wire logic [5:0]  fine_delay_code, fine_delay_applied
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire wr_c = reg_wr && reg_addr == 4'hC;
  a_coarse_store:
  assert property (wr_c |=> {coarse_delay_code, delay_adjust_select, duty_cycle_stabilizer_en} == $past(reg_wdata[15:2]))
  else $error("aperture store");
  a_range_apply:
  assert property (reg_wr && reg_addr == 4'hB && reg_wdata[14] |=> ##1 range_magnitude == $past(reg_wdata[14:0], 2))
  else $error("range apply");
  a_read_idle:
  assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read idle");
  a_read_aper:
  assert property (reg_rd && reg_addr == 4'hC |=> reg_rdata == {coarse_delay_code, delay_adjust_select,
    duty_cycle_stabilizer_en, 2'b00}) else $error("aperture read");
  a_clamp_max:
  assert property (delay_adjust_select |=> coarse_delay_applied == ($past(coarse_delay_code) > 12'h97F ?
    12'h97F : $past(coarse_delay_code))) else $error("coarse clamp");
  a_gate_off:
  assert property (!delay_adjust_select |=> coarse_delay_applied == 12'h000 && fine_delay_applied == 6'h00)
  else $error("delay gate");
  a_fine_pass:
  assert property (delay_adjust_select |=> fine_delay_applied == $past(fine_delay_code)) else $error("fine pass");
  a_sat_flag:
  assert property (1'b1 |=> coarse_delay_saturated == ($past(coarse_delay_code) > 12'h97F)) else $error("sat flag");
  a_hold_code:
  assert property (!wr_c |=> $stable(coarse_delay_code)) else $error("code hold");
endmodule
bind ara_regs ara_regs_sva ara_regs_sva_inst (.*);

// File: testbench/ara_host.sv
// Purpose: host controller on the register port
// Assumes: called just after a rising edge
// Notes:   idle cycle after each access keeps strobes apart
`timescale 1ns/100ps
module ara_host (
  input  wire logic        clock,
  input  wire logic [15:0] reg_rdata,
  output logic      [3:0]  reg_addr = 4'h0,
  output logic      [15:0] reg_wdata = 16'h0000,
  output logic             reg_wr = 1'b0,
  output logic             reg_rd = 1'b0
);
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= (a == 4'hC) ? (d & 16'hFFFC) : d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(posedge clock);
    // data stand only in the cycle after the strobe; taken at its closing edge
    d = reg_rdata;
  endtask
endmodule

// File: testbench/ara_regs_tb.sv
// Purpose: self-checking run of the range and aperture registers
// Assumes: reset held 20 cycles
// Notes:   extended mode low until the last range scenario
`timescale 1ns/100ps
module ara_regs_tb;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        extended_control_mode = 1'b0;
  logic [5:0]  fine_delay_code = 6'h2A;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic        reg_wr, reg_rd, delay_adjust_select, duty_cycle_stabilizer_en, coarse_delay_saturated;
  logic [14:0] range_magnitude;
  logic [11:0] coarse_delay_code, coarse_delay_applied;
  logic [5:0]  fine_delay_applied;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  always #25 clock = ~clock;
  ara_host ara_host_inst (.*);
  ara_regs ara_regs_inst (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrc(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
    ara_host_inst.wr(a, d);
    ara_host_inst.rd(a, rv);
    chk(rv, e);
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // run is about 52 cycles, ceiling well above
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      end_sim;
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    ara_host_inst.rd(4'hB, rv);
    chk(rv, 16'h4000);
    ara_host_inst.rd(4'hC, rv);
    chk(rv, 16'h0004);
    chk({15'h0000, duty_cycle_stabilizer_en}, 16'h0001);
    wrc(4'hC, 16'h97F8, 16'h97F8); // slow sampling clock assumed, so maximum code allowed
    chk({4'h0, coarse_delay_applied}, 16'h097F);
    chk({10'h000, fine_delay_applied}, 16'h002A);
    wrc(4'hC, 16'hFFFF, 16'hFFFC);
    chk({4'h0, coarse_delay_applied}, 16'h097F);
    chk({15'h0000, coarse_delay_saturated}, 16'h0001);
    wrc(4'hC, 16'h1230, 16'h1230);
    chk({4'h0, coarse_delay_applied}, 16'h0000);
    chk({2'b00, coarse_delay_code, delay_adjust_select, duty_cycle_stabilizer_en}, 16'h048C);
    wrc(4'hB, 16'hFFFF, 16'h7FFF);
    chk({1'b0, range_magnitude}, 16'h7FFF);
    wrc(4'hB, 16'h1234, 16'h1234);
    chk({1'b0, range_magnitude}, 16'h4000);
    extended_control_mode <= 1'b1;
    repeat (2) @(posedge clock);
    chk({1'b0, range_magnitude}, 16'h1234);
    wrc(4'h9, 16'h1234, 16'h0000);
    ara_host_inst.rd(4'hC, rv);
    chk(rv, 16'h1230);
    end_sim;
  end
endmodule
